// ==== common/sram_host_pkg.sv ====
/*
 * Constants for the host-side controller of a byte-wide asynchronous static
 * memory: geometry, pin timing figures in ns and their cycle counts.
 * Assumes a single 100 MHz clock; every figure is rounded up to whole cycles.
 */
package sram_host_pkg;

    // =====================================================================
    // geometry
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;

    // =====================================================================
    // clock and synchroniser
    localparam int CLK_PERIOD_NS = 10;
    localparam int SYNC_STAGES = 2;
    localparam int TIMER_W = 20;

    // least time in ns to whole cycles, never below one
    function automatic int cycles_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // =====================================================================
    // pin timing, fast grade then slow grade
    localparam int T_ADDR_TO_WRISE_FAST_NS = 50;
    localparam int T_ADDR_TO_WRISE_SLOW_NS = 55;
    localparam int T_WPULSE_FAST_NS = 45;
    localparam int T_WPULSE_SLOW_NS = 50;
    localparam int T_ACCESS_FAST_NS = 55;
    localparam int T_ACCESS_SLOW_NS = 70;
    localparam int T_OE_ACCESS_FAST_NS = 30;
    localparam int T_OE_ACCESS_SLOW_NS = 35;
    localparam int T_DISABLE_FAST_NS = 20;
    localparam int T_DISABLE_SLOW_NS = 25;
    localparam int T_RECOVERY_MS = 5;

    localparam int RECOVERY_CYCLES = T_RECOVERY_MS * 1000000 / CLK_PERIOD_NS;

    // =====================================================================
    // controller states
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_WR_LOW  = 3'b001,
        ST_WR_END  = 3'b010,
        ST_RD_WAIT = 3'b011,
        ST_RD_FLOAT = 3'b100,
        ST_RETAIN  = 3'b101,
        ST_RECOVER = 3'b110
    } ctrl_state_t;

endpackage

// ==== src/interval_timer.sv ====
/*
 * Down counter that times how long the controller stays in one state.
 * Assumes the loader asserts i_load for one cycle with the wanted length
 * minus one; o_zero is high once the count has run out.
 */
module interval_timer #(
    parameter int WIDTH = 20
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_value,
    output logic o_zero
);

    logic [WIDTH-1:0] count_reg;

    // =====================================================================
    // counting
    // load wins over the decrement so a new state starts a fresh interval
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_reg <= '0;
        end else if (i_load) begin
            count_reg <= i_value;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign o_zero = (count_reg == '0);

endmodule // interval_timer

// ==== src/sram_host_ctrl.sv ====
/*
 * Host-side controller for a 128K x 8 asynchronous static memory: turns one
 * read or write request into strobe sequences on the memory pins, and
 * handles entry into and recovery from low-supply data retention.
 * Assumes a 100 MHz clock, the memory wired straight to the pins, and a
 * board-level resolver that builds the data wire from value and enable.
 */

// Functional notes
// - writes happen only while both selects active and write strobe low.
// - address stable 50/55 ns before write strobe rises.
// - deselect no later than supply starts dropping into retention.
// - stay deselected 5 ms after supply returns before any access.
// - during retention hold high select at a full rail level.
// - never drive data bus while memory drives its outputs.
module sram_host_ctrl
    import sram_host_pkg::*;
#(
    parameter bit SLOW_GRADE = 1'b0,
    parameter int RECOVERY_LEN = RECOVERY_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    output logic o_busy,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_rvalid,
    output logic o_write_done,
    input wire logic i_retention_req,
    output logic o_retention_ready,
    output logic [ADDR_W-1:0] o_word_address_lines,
    output logic o_select_active_low_n,
    output logic o_select_active_high,
    output logic o_write_strobe_n,
    output logic o_output_gate_n,
    output logic [DATA_W-1:0] o_shared_data_pins,
    output logic o_shared_data_oe_n,
    input wire logic [DATA_W-1:0] i_shared_data_pins
);

    // =====================================================================
    // cycle counts for the chosen grade
    localparam int WR_ADDR = SLOW_GRADE ? T_ADDR_TO_WRISE_SLOW_NS : T_ADDR_TO_WRISE_FAST_NS;
    localparam int WR_PULSE = SLOW_GRADE ? T_WPULSE_SLOW_NS : T_WPULSE_FAST_NS;
    localparam int WR_LOW = cycles_min((WR_ADDR > WR_PULSE) ? WR_ADDR : WR_PULSE);
    localparam int ACC_S = cycles_min(SLOW_GRADE ? T_ACCESS_SLOW_NS : T_ACCESS_FAST_NS);
    localparam int ACC_OE = cycles_min(SLOW_GRADE ? T_OE_ACCESS_SLOW_NS : T_OE_ACCESS_FAST_NS);
    // gate and select fall together, so the longer access governs
    localparam int RD_WAIT = ((ACC_S > ACC_OE) ? ACC_S : ACC_OE) + SYNC_STAGES;
    localparam int DIS = cycles_min(SLOW_GRADE ? T_DISABLE_SLOW_NS : T_DISABLE_FAST_NS);
    localparam int RD_LAT = RD_WAIT + 1;

    ctrl_state_t state_reg;
    ctrl_state_t state_next;
    logic timer_zero;
    logic timer_load;
    logic [TIMER_W-1:0] timer_value;
    logic take;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] sync1_reg;
    logic [DATA_W-1:0] sync2_reg;

    interval_timer #(
        .WIDTH(TIMER_W)
    ) u_timer (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_load(timer_load),
        .i_value(timer_value),
        .o_zero(timer_zero)
    );

    // =====================================================================
    // sequencing
    assign take = (state_reg == ST_IDLE) && i_req && !i_retention_req;

    // next state and interval length for the state being entered
    always_comb begin
        state_next = state_reg;
        timer_load = 1'b0;
        timer_value = '0;
        unique case (state_reg)
            ST_IDLE: begin
                if (i_retention_req) begin
                    state_next = ST_RETAIN;
                end else if (i_req && i_write) begin
                    state_next = ST_WR_LOW;
                    timer_load = 1'b1;
                    timer_value = TIMER_W'(WR_LOW - 1);
                end else if (i_req) begin
                    state_next = ST_RD_WAIT;
                    timer_load = 1'b1;
                    timer_value = TIMER_W'(RD_WAIT - 1);
                end
            end
            ST_WR_LOW: begin
                if (timer_zero) begin
                    state_next = ST_WR_END;
                end
            end
            ST_WR_END: begin
                state_next = ST_IDLE;
            end
            ST_RD_WAIT: begin
                if (timer_zero) begin
                    state_next = ST_RD_FLOAT;
                    timer_load = 1'b1;
                    timer_value = TIMER_W'(DIS - 1);
                end
            end
            ST_RD_FLOAT: begin
                if (timer_zero) begin
                    state_next = ST_IDLE;
                end
            end
            ST_RETAIN: begin
                if (!i_retention_req) begin
                    state_next = ST_RECOVER;
                    timer_load = 1'b1;
                    timer_value = TIMER_W'(RECOVERY_LEN - 1);
                end
            end
            ST_RECOVER: begin
                if (timer_zero) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // =====================================================================
    // memory pins
    // selects and strobe fall together: the memory floats its outputs then
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_select_active_low_n <= 1'b1;
            o_select_active_high <= 1'b0;
            o_write_strobe_n <= 1'b1;
            o_output_gate_n <= 1'b1;
        end else begin
            o_select_active_low_n <= !(state_next inside {ST_WR_LOW, ST_WR_END, ST_RD_WAIT});
            // driven low, a full rail, through idle and retention
            o_select_active_high <= state_next inside {ST_WR_LOW, ST_WR_END, ST_RD_WAIT};
            o_write_strobe_n <= (state_next != ST_WR_LOW);
            o_output_gate_n <= (state_next != ST_RD_WAIT);
        end
    end

    // data is driven only while the gate is high; it stays one cycle
    // past the strobe rise so the capture edge sees stable data
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_shared_data_oe_n <= 1'b1;
            o_shared_data_pins <= '0;
        end else begin
            o_shared_data_oe_n <= !(state_next inside {ST_WR_LOW, ST_WR_END});
            o_shared_data_pins <= take ? i_wdata : wdata_reg;
        end
    end

    // address and write data held for the whole access
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_word_address_lines <= '0;
            wdata_reg <= '0;
        end else if (take) begin
            o_word_address_lines <= i_addr;
            wdata_reg <= i_wdata;
        end
    end

    // =====================================================================
    // read data capture
    // two stages because the pins change on the memory's own timing
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= i_shared_data_pins;
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= '0;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= (state_reg == ST_RD_WAIT) && timer_zero;
            if ((state_reg == ST_RD_WAIT) && timer_zero) begin
                o_rdata <= sync2_reg;
            end
        end
    end

    // =====================================================================
    // user status
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_busy <= 1'b0;
            o_write_done <= 1'b0;
            o_retention_ready <= 1'b0;
        end else begin
            o_busy <= (state_next != ST_IDLE);
            o_write_done <= (state_reg == ST_WR_END);
            o_retention_ready <= (state_next == ST_RETAIN);
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    logic [3:0] addr_age_reg;
    logic [3:0] wlow_cnt_reg;
    logic [TIMER_W-1:0] desel_cnt_reg;
    logic seen_retain_reg;

    // helper counters read only by the checks below
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            addr_age_reg <= '0;
            wlow_cnt_reg <= '0;
            desel_cnt_reg <= '0;
            seen_retain_reg <= 1'b0;
        end else begin
            addr_age_reg <= (take && (i_addr != o_word_address_lines)) ? 4'h0 :
                            (addr_age_reg == 4'hF) ? addr_age_reg : addr_age_reg + 4'h1;
            wlow_cnt_reg <= o_write_strobe_n ? 4'h0 : wlow_cnt_reg + 4'h1;
            desel_cnt_reg <= (!o_select_active_low_n || i_retention_req) ? '0 :
                             (&desel_cnt_reg) ? desel_cnt_reg : desel_cnt_reg + 1'b1;
            if (state_reg == ST_RETAIN) begin
                seen_retain_reg <= 1'b1;
            end else if (!o_select_active_low_n) begin
                seen_retain_reg <= 1'b0;
            end
        end
    end

    a_write_needs_select: assert property (!o_write_strobe_n |->
        !o_select_active_low_n && o_select_active_high)
        else $error("write strobe low while deselected");
    a_write_pulse_len: assert property ($rose(o_write_strobe_n) |->
        $past(wlow_cnt_reg) == 4'(WR_LOW - 1))
        else $error("write strobe low time wrong");
    a_addr_setup_wrise: assert property ($rose(o_write_strobe_n) |->
        addr_age_reg >= 4'(WR_LOW))
        else $error("address changed too close to strobe rise");
    a_no_bus_fight: assert property (!o_shared_data_oe_n |-> o_output_gate_n)
        else $error("data driven while memory output gate open");
    a_float_gap: assert property ($rose(o_output_gate_n) |->
        o_shared_data_oe_n [*2])
        else $error("bus driven before memory output floats");
    a_retain_deselect: assert property (o_retention_ready |->
        o_select_active_low_n && !o_select_active_high)
        else $error("selected during retention");
    a_recover_wait: assert property ($fell(o_select_active_low_n) && seen_retain_reg |->
        $past(desel_cnt_reg) >= TIMER_W'(RECOVERY_LEN))
        else $error("access too soon after retention");
    a_read_latency: assert property (take && !i_write |-> ##RD_LAT o_rvalid)
        else $error("read data late or early");

    c_write_done: cover property (take && i_write ##[1:20] o_write_done);
    c_read_valid: cover property (take && !i_write ##[1:20] o_rvalid);
    c_retention: cover property (o_retention_ready ##1 !i_retention_req);
    c_back_to_back: cover property (o_write_done ##[1:3] o_busy);

endmodule // sram_host_ctrl

// ==== dv/sram_device_model.sv ====
/*
 * Behavioural model of the byte-wide static memory at the pins of the
 * host controller, with a count of host-side timing faults.
 * Assumes the bench resolves the data wire and feeds it back here.
 */
module sram_device_model
    import sram_host_pkg::*;
(
    input wire logic [ADDR_W-1:0] i_word_address_lines,
    input wire logic i_select_active_low_n,
    input wire logic i_select_active_high,
    input wire logic i_write_strobe_n,
    input wire logic i_output_gate_n,
    input wire logic [DATA_W-1:0] i_shared_data_pins,
    input wire logic i_host_drive_n,
    input wire logic i_supply_low,
    output logic [DATA_W-1:0] o_shared_data_pins,
    output logic [7:0] o_fault_cnt
);
    timeunit 1ns;
    timeprecision 100ps;

    // =====================================================================
    // array and pin decode
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] val = 8'h00;
    logic drive = 1'b0;
    logic rd_on, wr_on;
    realtime t_addr = 0;
    // one tally per fault kind, so each has a single writer
    int setup_faults = 0;
    int fight_faults = 0;
    int supply_faults = 0;
    assign rd_on = !i_select_active_low_n && i_select_active_high
        && i_write_strobe_n && !i_output_gate_n;
    assign wr_on = !i_select_active_low_n && i_select_active_high
        && !i_write_strobe_n;
    // released wire shows the inverse, never a stale match
    assign o_shared_data_pins = drive ? val : ~val;

    assign o_fault_cnt = 8'(setup_faults + fight_faults + supply_faults);

    // =====================================================================
    // read path: garbage first, valid at the fast-grade access time
    always @(rd_on) begin
        if (rd_on) begin
            val = ~mem[i_word_address_lines];
            drive <= #5 1'b1;
            val <= #(T_ACCESS_FAST_NS) mem[i_word_address_lines];
        end else begin
            drive <= #(T_DISABLE_FAST_NS) 1'b0;
        end
    end

    // =====================================================================
    // write capture on the first terminating edge, with setup check
    always @(i_word_address_lines) t_addr = $realtime;
    // the x-to-0 step at time zero is not a write and must not count
    always @(negedge wr_on) begin
        if ($realtime > 0) begin
            mem[i_word_address_lines] = i_shared_data_pins;
            if ($realtime - t_addr < T_ADDR_TO_WRISE_FAST_NS) setup_faults++;
        end
    end

    // host must not fight the outputs
    always @(negedge i_host_drive_n or posedge drive) begin
        #1 if (!i_host_drive_n && drive) fight_faults++;
    end

    // selected while the supply is low is a host fault
    always @(posedge i_supply_low or negedge i_select_active_low_n
        or posedge i_select_active_high) begin
        #1 if (i_supply_low && (!i_select_active_low_n || i_select_active_high))
            supply_faults++;
    end
endmodule // sram_device_model

// ==== dv/async_sram_128kx8_port_bench.sv ====
/*
 * Self-checking bench for the static memory host controller, fast grade.
 * Assumes the device model in dv/ and a short recovery count of 20.
 */
module async_sram_128kx8_port_bench
    import sram_host_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int REC_LEN = 20;
    // edges counted after the taking edge: 5 strobe-low cycles plus one
    // select hold; 6 access cycles plus 2 sync stages; then 2 float cycles
    localparam int WR_DONE_K = 6;
    localparam int RD_VALID_K = 8;
    localparam int RD_IDLE_K = 10;
    logic clk, rst_n, req, wr, ret_req, supply_low;
    logic [ADDR_W-1:0] addr, pin_addr;
    logic [DATA_W-1:0] wdata, rdata, ctrl_d, mem_d, bus;
    logic busy, rvalid, wdone, ret_rdy, sel_n, sel_h, we_n, gate_n, host_oe_n;
    logic [7:0] fault_cnt;
    int error_cnt, compares, cycles;
    assign bus = !host_oe_n ? ctrl_d : mem_d; // resolved data wire

    sram_host_ctrl #(.SLOW_GRADE(1'b0), .RECOVERY_LEN(REC_LEN)) sram_host_ctrl_inst (
        .i_ref_clk(clk), .i_reset_n(rst_n), .i_req(req), .i_write(wr),
        .i_addr(addr), .i_wdata(wdata), .o_busy(busy), .o_rdata(rdata),
        .o_rvalid(rvalid), .o_write_done(wdone), .i_retention_req(ret_req),
        .o_retention_ready(ret_rdy), .o_word_address_lines(pin_addr),
        .o_select_active_low_n(sel_n), .o_select_active_high(sel_h),
        .o_write_strobe_n(we_n), .o_output_gate_n(gate_n),
        .o_shared_data_pins(ctrl_d), .o_shared_data_oe_n(host_oe_n),
        .i_shared_data_pins(bus));

    sram_device_model sram_device_model_inst (
        .i_word_address_lines(pin_addr), .i_select_active_low_n(sel_n),
        .i_select_active_high(sel_h), .i_write_strobe_n(we_n),
        .i_output_gate_n(gate_n), .i_shared_data_pins(bus),
        .i_host_drive_n(host_oe_n), .i_supply_low(supply_low),
        .o_shared_data_pins(mem_d), .o_fault_cnt(fault_cnt));

    // =====================================================================
    // reporting
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares=%0d mismatches=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // =====================================================================
    // one request each; latency counted from the taking edge
    task automatic do_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int k;
        @(posedge clk);
        #1 req = 1'b1;
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1 req = 1'b0;
        k = 0;
        while (wdone !== 1'b1 && k < 20) begin
            @(posedge clk);
            #1 k++;
            check(gate_n, 1'b1);
        end
        check(k, WR_DONE_K);
        check(busy, 1'b0);
        @(posedge clk);
        #1 check(wdone, 1'b0);
    endtask

    task automatic do_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int k;
        @(posedge clk);
        #1 req = 1'b1;
        wr = 1'b0;
        addr = a;
        @(posedge clk);
        #1 req = 1'b0;
        k = 0;
        while (rvalid !== 1'b1 && k < 20) begin
            @(posedge clk);
            #1 k++;
        end
        check(k, RD_VALID_K);
        check(rdata, d);
        check(pin_addr, a);
        while (busy !== 1'b0 && k < 40) begin
            @(posedge clk);
            #1 k++;
            check(rvalid, 1'b0);
        end
        check(k, RD_IDLE_K);
    endtask

    // =====================================================================
    // scenarios
    task automatic test_rw();
        logic [ADDR_W-1:0] a [4] = '{17'h00000, 17'h1FFFF, 17'h0AAAA, 17'h15555};
        logic [DATA_W-1:0] d [4] = '{8'h5A, 8'hA5, 8'h0F, 8'hF0};
        for (int i = 0; i < 4; i++) do_write(a[i], d[i]);
        for (int i = 0; i < 4; i++) do_read(a[i], d[i]);
        do_write(a[0], 8'h3C); // overwrite then read straight after
        do_read(a[0], 8'h3C);
        $display("test rw done");
    endtask

    // retention wins over a pending write; recovery keeps the chip off
    task automatic test_retention();
        int k;
        logic bad;
        @(posedge clk);
        #1 ret_req = 1'b1;
        req = 1'b1;
        wr = 1'b1;
        addr = 17'h0AAAA;
        wdata = 8'hEE;
        repeat (2) @(posedge clk);
        #1 check(ret_rdy, 1'b1);
        check(sel_n, 1'b1);
        check(sel_h, 1'b0);
        supply_low = 1'b1;
        repeat (5) @(posedge clk);
        #1 check(we_n, 1'b1);
        supply_low = 1'b0;
        ret_req = 1'b0;
        req = 1'b0;
        k = 0;
        bad = 1'b0;
        while (busy === 1'b1 && k < 60) begin
            @(posedge clk);
            #1 k++;
            if (sel_n !== 1'b1 || sel_h !== 1'b0) bad = 1'b1;
        end
        check(bad, 1'b0);
        check(k >= REC_LEN, 1'b1);
        check(ret_rdy, 1'b0);
        do_read(17'h0AAAA, 8'h0F);
        $display("test retention done");
    endtask

    // =====================================================================
    // clock, hang guard and main sequence
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // limit is over twenty times the expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    initial begin
        rst_n = 1'b0;
        req = 1'b0;
        wr = 1'b0;
        addr = '0;
        wdata = '0;
        ret_req = 1'b0;
        supply_low = 1'b0;
        error_cnt = 0;
        compares = 0;
        cycles = 0;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        test_rw();
        test_retention();
        check(fault_cnt, 8'h00);
        tally_and_finish();
    end
endmodule // async_sram_128kx8_port_bench
